// ===== ring_osc_ctrl.sv
// Register file and control logic of the ring oscillator
//
// Design decision made here: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module ring_osc_ctrl
  import ring_osc_pkg::*;
#(
  parameter int COUNT_W = 8
)(
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                srst,
  // Wishbone classic slave
  input  wire logic [31:0]         wb_adr_i,
  input  wire logic [31:0]         wb_dat_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic                wb_we_i,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  // Events and samples from the oscillator side
  input  wire logic                wake_irq,
  input  wire logic                osc_sample,
  input  wire logic                osc_tick,
  // Controls to the oscillator
  output logic                     osc_enable,
  output logic                     osc_stop,
  output ring_osc_pkg::range_e     stage_range_select,
  output logic      [15:0]         stage_drive,
  output logic      [5:0]          divide_ratio,
  output logic      [3:0]          phase_setting
);

  typedef struct packed {
    logic               ack;
    logic [31:0]        rdata;
    logic [11:0]        enable_code;
    logic [11:0]        range_code;
    logic [31:0]        drive_low;
    logic [31:0]        drive_high;
    logic [31:0]        pause_code;
    logic [11:0]        divider_code;
    logic [11:0]        phase_code;
    logic               invalid_write_flag;
    logic [COUNT_W-1:0] down_count;
    logic               random_bit;
  } regs_s;

  regs_s st;
  regs_s next_st;
  pause_if pif ();

  // Byte-lane merge of a write into the current register image
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return r;
  endfunction

  // Range code to ring length; unknown codes fall back to eight stages
  function automatic range_e decode_range(input logic [11:0] code);
    range_e r;
    r = STAGES_8;
    if (code == RANGE_MEDIUM) r = STAGES_6;
    if (code == RANGE_HIGH) r = STAGES_4;
    if (code == RANGE_OVER) r = STAGES_2;
    return r;
  endfunction

  function automatic logic range_valid(input logic [11:0] code);
    return code == RANGE_LOW || code == RANGE_MEDIUM || code == RANGE_HIGH || code == RANGE_OVER;
  endfunction

  // Set-bit count of a three-bit drive field
  function automatic logic [1:0] ones(input logic [2:0] f);
    return 2'(f[0]) + 2'(f[1]) + 2'(f[2]);
  endfunction

  // Four stage drives of one keyed register, zero without the key
  function automatic logic [7:0] drives(input logic [31:0] r);
    logic [7:0] d;
    d = 8'h00;
    if (r[31:WRITE_KEY_LSB] == DRIVE_KEY) begin
      for (int i = 0; i < 4; i++) begin
        d[i*2 +: 2] = ones(r[i*4 +: 3]);
      end
    end
    return d;
  endfunction

  // Bus decode
  logic        in_bank;
  logic [7:0]  offset;
  logic        access;
  logic        wr_now;
  logic [31:0] read_value;
  logic [31:0] cur_value;
  logic [31:0] wr_value;
  logic        bad_code;

  assign offset  = {wb_adr_i[7:2], 2'b00};
  assign in_bank = (wb_adr_i[31:8] == OSC_BASE_ADDR[31:8]) && (wb_adr_i[7:2] <= LAST_WORD);
  assign access  = wb_cyc_i && wb_stb_i;
  // The write lands on the edge at which the master sees ack
  assign wr_now  = access && st.ack && wb_we_i && in_bank;

  // Outputs
  assign wb_ack_o           = st.ack;
  assign wb_dat_o           = st.rdata;
  assign osc_enable         = (st.enable_code != ENABLE_OFF);
  assign osc_stop           = pif.osc_stop;
  assign stage_range_select = decode_range(st.range_code);
  assign stage_drive        = {drives(st.drive_high), drives(st.drive_low)};

  // Divider code: key in 11:5, ratio in 4:0, zero meaning 32, bad key meaning 31
  always_comb begin
    if (st.divider_code[11:5] != DIVIDER_KEY) divide_ratio = 6'd31;
    else if (st.divider_code[4:0] == 5'h00) divide_ratio = 6'd32;
    else divide_ratio = {1'b0, st.divider_code[4:0]};
  end

  // A bad phase key keeps the output enabled and passes only bit 2 of the code through
  assign phase_setting = (st.phase_code[11:4] == PHASE_KEY) ? st.phase_code[3:0]
                                                            : {1'b1, st.phase_code[2], 2'b00};

  // Sequencer hookup
  assign pif.osc_enable = osc_enable;
  assign pif.pause_req  = wr_now && offset == OFS_PAUSE && wr_value == PAUSE_CODE;
  assign pif.wake_req   = wr_now && offset == OFS_PAUSE && wr_value != PAUSE_CODE;

  pause_seq u_seq (
    .sys_clk  (sys_clk),
    .srst     (srst),
    .wake_irq (wake_irq),
    .pif      (pif)
  );

  // Read image; reserved bits stay zero
  always_comb begin
    read_value = 32'h00000000;
    unique case (offset)
      OFS_CONTROL:    read_value = {8'h00, st.enable_code, st.range_code};
      OFS_DRIVE_LOW:  read_value = st.drive_low;
      OFS_DRIVE_HIGH: read_value = st.drive_high;
      OFS_PAUSE:      read_value = st.pause_code;
      OFS_DIVIDER:    read_value = {20'h00000, st.divider_code};
      OFS_PHASE:      read_value = {20'h00000, st.phase_code};
      OFS_STATUS: begin
        read_value[STABLE_BIT]    = pif.stable;
        read_value[BAD_WRITE_BIT] = st.invalid_write_flag;
        read_value[RUNNING_BIT]   = osc_enable && !pif.osc_stop;
        read_value[ENABLED_BIT]   = osc_enable;
      end
      OFS_RANDOM:     read_value[0] = st.random_bit;
      OFS_DOWN_COUNT: read_value[COUNT_W-1:0] = st.down_count;
      default:        read_value = 32'h00000000;
    endcase
    if (!in_bank) read_value = 32'h00000000;
  end

  assign cur_value = read_value;
  assign wr_value  = merge(cur_value, wb_dat_i, wb_sel_i);

  // Invalid code detection for each keyed register
  always_comb begin
    bad_code = 1'b0;
    unique case (offset)
      OFS_CONTROL:    bad_code = !(wr_value[23:12] == ENABLE_OFF || wr_value[23:12] == ENABLE_ON)
                                 || !range_valid(wr_value[11:0]);
      OFS_DRIVE_LOW:  bad_code = wr_value[31:16] != DRIVE_KEY;
      OFS_DRIVE_HIGH: bad_code = wr_value[31:16] != DRIVE_KEY;
      OFS_PAUSE:      bad_code = wr_value != PAUSE_CODE && wr_value != WAKE_CODE;
      OFS_DIVIDER:    bad_code = wr_value[11:5] != DIVIDER_KEY;
      OFS_PHASE:      bad_code = wr_value[11:4] != PHASE_KEY;
      default:        bad_code = 1'b0;
    endcase
  end

  // Next register image
  always_comb begin
    next_st = st;
    // Ack rises one cycle after the request and drops the cycle after
    next_st.ack = access && !st.ack;
    if (access && !st.ack) next_st.rdata = read_value;
    next_st.random_bit = osc_sample;
    // Oscillator ticks run the counter down and it parks at zero
    if (osc_tick && st.down_count != '0) next_st.down_count = st.down_count - 1'b1;
    if (wr_now) begin
      unique case (offset)
        OFS_CONTROL: begin
          next_st.enable_code = wr_value[23:12];
          next_st.range_code  = wr_value[11:0];
        end
        OFS_DRIVE_LOW:  next_st.drive_low  = wr_value & {16'hFFFF, DRIVE_MASK};
        OFS_DRIVE_HIGH: next_st.drive_high = wr_value & {16'hFFFF, DRIVE_MASK};
        // Anything but the pause code reads back as wake
        OFS_PAUSE:      next_st.pause_code = (wr_value == PAUSE_CODE) ? PAUSE_CODE : WAKE_CODE;
        OFS_DIVIDER:    next_st.divider_code = wr_value[11:0];
        OFS_PHASE:      next_st.phase_code = wr_value[11:0];
        OFS_STATUS: begin
          if (wr_value[BAD_WRITE_BIT]) next_st.invalid_write_flag = 1'b0;
        end
        OFS_DOWN_COUNT: next_st.down_count = wr_value[COUNT_W-1:0];
        default: next_st.down_count = next_st.down_count;
      endcase
      // A fresh bad write beats a clear in the same cycle
      if (bad_code) next_st.invalid_write_flag = 1'b1;
    end
    // A wake interrupt while stopped returns the pause register to wake
    if (pif.osc_stop && wake_irq) next_st.pause_code = WAKE_CODE;
  end

  // Register update; power-up values
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st                    <= '0;
      st.enable_code        <= ENABLE_ON;
      st.range_code         <= RANGE_RESET;
      st.pause_code         <= WAKE_CODE;
      st.divider_code       <= DIVIDER_RESET;
      st.phase_code         <= PHASE_RESET;
      st.random_bit         <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  // Assertions watch the register image and the decoded outputs; the bus ones
  // look one cycle after the request, the cycle in which ack marks the read data valid.

  // Bus handshake and decode
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_follows_a: assert property (access && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  bank_miss_a: assert property (access && !wb_ack_o && !in_bank |=> wb_dat_o == 32'h00000000)
    else $error("unmapped read returned data");

  // Enable code; the reset check keeps its own disable so it sees the first free edge
  disable_code_a: assert property (wr_now && offset == OFS_CONTROL && wr_value[23:12] == ENABLE_OFF
                                   |=> !osc_enable)
    else $error("disable code left oscillator on");
  other_code_a: assert property (wr_now && offset == OFS_CONTROL && wr_value[23:12] != ENABLE_OFF
                                 |=> osc_enable)
    else $error("non-disable code turned oscillator off");
  reset_on_a: assert property (@(posedge sys_clk) disable iff (1'b0) $past(srst) |-> osc_enable
                               && stage_range_select == STAGES_8)
    else $error("oscillator not enabled after reset");

  // Range decode; undefined codes fall back to the longest ring
  range_medium_a: assert property (st.range_code == RANGE_MEDIUM |-> stage_range_select == STAGES_6)
    else $error("medium range code not decoded");
  range_high_a: assert property (st.range_code == RANGE_HIGH |-> stage_range_select == STAGES_4)
    else $error("high range code not decoded");
  range_over_a: assert property (st.range_code == RANGE_OVER |-> stage_range_select == STAGES_2)
    else $error("overspeed range code not decoded");
  range_default_a: assert property (!range_valid(st.range_code) |-> stage_range_select == STAGES_8)
    else $error("undefined range code not eight stages");

  // Drive keys, counts and reserved bits
  key_gate_a: assert property (wr_now && offset == OFS_DRIVE_LOW && wr_value[31:16] != DRIVE_KEY
                               |=> stage_drive[7:0] == 8'h00)
    else $error("drive applied without key");
  key_gate_low_a: assert property (st.drive_low[31:16] != DRIVE_KEY |-> stage_drive[7:0] == 8'h00)
    else $error("low drive applied without key");
  key_gate_high_a: assert property (st.drive_high[31:16] != DRIVE_KEY |-> stage_drive[15:8] == 8'h00)
    else $error("high drive applied without key");
  drive_full_a: assert property (st.drive_low[31:16] == DRIVE_KEY && st.drive_low[14:12] == 3'h7
                                 |-> stage_drive[7:6] == 2'h3)
    else $error("three set bits not quadruple drive");
  drive_reserved_a: assert property ((st.drive_low[15:0] & ~DRIVE_MASK) == 16'h0000
                                     && (st.drive_high[15:0] & ~DRIVE_MASK) == 16'h0000)
    else $error("reserved drive bits stored");
  high_offset_a: assert property (access && !wb_ack_o && in_bank && offset == OFS_DRIVE_HIGH
                                  |=> wb_dat_o == $past(st.drive_high))
    else $error("high drive register not at its offset");

  // Pause register and status; a wake interrupt while stopped, in the same cycle as a pause
  // write, returns the register to wake, so the pause check leaves that cycle out
  pause_stop_a: assert property (pif.pause_req && osc_enable |=> osc_stop)
    else $error("pause code did not stop oscillator");
  pause_code_a: assert property (wr_now && offset == OFS_PAUSE && wr_value == PAUSE_CODE && !wake_irq
                                 |=> st.pause_code == PAUSE_CODE)
    else $error("pause code not held");
  pause_wake_a: assert property (wr_now && offset == OFS_PAUSE && wr_value != PAUSE_CODE
                                 |=> st.pause_code == WAKE_CODE)
    else $error("non-pause write did not select wake");
  bad_flag_a: assert property (wr_now && offset == OFS_PAUSE && wr_value != PAUSE_CODE
                               && wr_value != WAKE_CODE |=> st.invalid_write_flag && st.pause_code == WAKE_CODE)
    else $error("invalid pause write not flagged");
  flag_clear_a: assert property (wr_now && offset == OFS_STATUS && wr_value[BAD_WRITE_BIT]
                                 |=> !st.invalid_write_flag)
    else $error("invalid write flag not cleared");
  stable_read_a: assert property (access && !wb_ack_o && in_bank && offset == OFS_STATUS
                                  |=> wb_dat_o[STABLE_BIT] == $past(pif.stable))
    else $error("status read lost the stable flag");

  // Down counter and random bit
  count_park_a: assert property (st.down_count == '0 && !(wr_now && offset == OFS_DOWN_COUNT)
                                 |=> st.down_count == '0)
    else $error("down counter moved past zero");
  count_step_a: assert property (osc_tick && st.down_count != '0 && !wr_now
                                 |=> st.down_count == $past(st.down_count) - 1'b1)
    else $error("down counter missed a tick");
  random_follow_a: assert property (!srst |=> st.random_bit == $past(osc_sample))
    else $error("random bit did not follow the sample");
  random_read_a: assert property (access && !wb_ack_o && in_bank && offset == OFS_RANDOM
                                  |=> wb_dat_o == {31'h00000000, $past(st.random_bit)})
    else $error("random bit read wrong");

endmodule
`default_nettype wire

// ===== ring_osc_pkg.sv
// Shared constants and types for the ring oscillator control block
package ring_osc_pkg;

  // Bus decode
  localparam logic [31:0] OSC_BASE_ADDR = 32'h40060000;
  localparam logic [5:0]  LAST_WORD     = 6'h08;

  // Register byte offsets
  localparam logic [7:0] OFS_CONTROL    = 8'h00;
  localparam logic [7:0] OFS_DRIVE_LOW  = 8'h04;
  localparam logic [7:0] OFS_DRIVE_HIGH = 8'h08;
  localparam logic [7:0] OFS_PAUSE      = 8'h0C;
  localparam logic [7:0] OFS_DIVIDER    = 8'h10;
  localparam logic [7:0] OFS_PHASE      = 8'h14;
  localparam logic [7:0] OFS_STATUS     = 8'h18;
  localparam logic [7:0] OFS_RANDOM     = 8'h1C;
  localparam logic [7:0] OFS_DOWN_COUNT = 8'h20;

  // Control register codes and field positions
  localparam int          ENABLE_LSB     = 12;
  localparam logic [11:0] ENABLE_OFF     = 12'hD1E;
  localparam logic [11:0] ENABLE_ON      = 12'hFAB;
  localparam logic [11:0] RANGE_LOW      = 12'hFA4;
  localparam logic [11:0] RANGE_MEDIUM   = 12'hFA5;
  localparam logic [11:0] RANGE_HIGH     = 12'hFA7;
  localparam logic [11:0] RANGE_OVER     = 12'hFA6;
  localparam logic [11:0] RANGE_RESET    = 12'hAA0;

  // Drive strength key and field mask
  localparam int          WRITE_KEY_LSB  = 16;
  localparam logic [15:0] DRIVE_KEY      = 16'h9696;
  localparam logic [15:0] DRIVE_MASK     = 16'h7777;

  // Pause register codes
  localparam logic [31:0] PAUSE_CODE     = 32'h636F6D61;
  localparam logic [31:0] WAKE_CODE      = 32'h77616B65;

  // Divider and phase codes
  localparam logic [6:0]  DIVIDER_KEY    = 7'h55;
  localparam logic [11:0] DIVIDER_RESET  = 12'hAB0;
  localparam logic [7:0]  PHASE_KEY      = 8'hAA;
  localparam logic [11:0] PHASE_RESET    = 12'h008;

  // Status bit positions
  localparam int STABLE_BIT    = 31;
  localparam int BAD_WRITE_BIT = 24;
  localparam int RUNNING_BIT   = 16;
  localparam int ENABLED_BIT   = 12;

  // Restart time after a wake event
  localparam int CLK_PERIOD_NS   = 25;
  localparam int RESTART_TIME_NS = 1000;
  localparam int RESTART_CYCLES  = RESTART_TIME_NS / CLK_PERIOD_NS;

  // Ring length selection
  typedef enum logic [1:0] {
    STAGES_8,
    STAGES_6,
    STAGES_4,
    STAGES_2
  } range_e;

  // Pause sequencer states
  typedef enum logic [1:0] {
    SEQ_OFF,
    SEQ_RESTART,
    SEQ_RUN,
    SEQ_PAUSED
  } seq_e;

endpackage

// ===== pause_if.sv
// Carrier between the register file and the pause sequencer
`timescale 1ns/1ps
`default_nettype none
interface pause_if;
  logic osc_enable;
  logic pause_req;
  logic wake_req;
  logic osc_stop;
  logic stable;

  modport regs (output osc_enable, output pause_req, output wake_req, input osc_stop, input stable);
  modport seq  (input osc_enable, input pause_req, input wake_req, output osc_stop, output stable);
endinterface
`default_nettype wire

// ===== pause_seq.sv
// Pause, wake and restart sequencer with the stable flag
`timescale 1ns/1ps
`default_nettype none
module pause_seq
  import ring_osc_pkg::*;
(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic srst,
  // Wake interrupt from GPIO edge or real-time clock
  input  wire logic wake_irq,
  // Register side
  pause_if.seq      pif
);

  typedef struct packed {
    seq_e       state;
    logic [6:0] timer;
  } seq_s;

  seq_s st;
  seq_s next_st;

  // Stop and stable follow the state directly
  assign pif.osc_stop = (st.state == SEQ_PAUSED);
  assign pif.stable   = (st.state == SEQ_RUN);

  // Next state; a disabled oscillator overrides everything
  always_comb begin
    next_st = st;
    unique case (st.state)
      SEQ_OFF: begin
        next_st.timer = 7'(RESTART_CYCLES);
        if (pif.osc_enable) next_st.state = SEQ_RESTART;
      end
      SEQ_RESTART: begin
        if (st.timer > 7'h01) next_st.timer = st.timer - 7'h01;
        else next_st.state = SEQ_RUN;
        // A pause written during the restart still wins, or the register and the ring would disagree
        if (pif.pause_req) next_st.state = SEQ_PAUSED;
      end
      SEQ_RUN: begin
        if (pif.pause_req) next_st.state = SEQ_PAUSED;
      end
      SEQ_PAUSED: begin
        // Only an interrupt, a wake write or a disable takes it out of pause
        if (wake_irq || pif.wake_req) begin
          next_st.state = SEQ_RESTART;
          next_st.timer = 7'(RESTART_CYCLES);
        end
      end
    endcase
    if (!pif.osc_enable) begin
      next_st.state = SEQ_OFF;
    end
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st.state <= SEQ_RESTART;
      st.timer <= 7'(RESTART_CYCLES);
    end else begin
      st <= next_st;
    end
  end

  // Upper bound of the restart window for the stable check
  localparam int RESTART_LIMIT = RESTART_CYCLES;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  wake_restart_a: assert property (pif.osc_stop && wake_irq && pif.osc_enable |=> !pif.osc_stop && !pif.stable)
    else $error("wake did not restart the oscillator");
  restart_hold_a: assert property ($fell(pif.osc_stop) && pif.osc_enable |-> !pif.stable [*8])
    else $error("stable raised too soon after wake");
  stable_late_a: assert property ($fell(pif.osc_stop) && pif.osc_enable
                                  |-> ##[1:RESTART_LIMIT] (pif.stable || pif.osc_stop || !pif.osc_enable))
    else $error("stable missing after restart time");

endmodule
`default_nettype wire

// ===== tb_ring_osc_ctrl.sv
// Self-checking bench for the ring oscillator control block
`timescale 1ns/1ps
`default_nettype none
module tb_ring_osc_ctrl;
  import ring_osc_pkg::*;

  // Design ports
  logic        sys_clk;
  logic        srst;
  logic [31:0] wb_adr_i;
  logic [31:0] wb_dat_i;
  logic [3:0]  wb_sel_i;
  logic        wb_we_i;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        wake_irq;
  logic        osc_sample;
  logic        osc_tick;
  logic        osc_enable;
  logic        osc_stop;
  range_e      stage_range_select;
  logic [15:0] stage_drive;
  logic [5:0]  divide_ratio;
  logic [3:0]  phase_setting;
  // Bench state
  int          n_fail;
  int          n_checks;
  logic [31:0] rd;
  logic [11:0] range_code [5];
  range_e      range_exp [5];

  ring_osc_ctrl #(.COUNT_W(8)) ring_osc_ctrl_i (
    .sys_clk(sys_clk), .srst(srst), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .wake_irq(wake_irq), .osc_sample(osc_sample), .osc_tick(osc_tick), .osc_enable(osc_enable),
    .osc_stop(osc_stop), .stage_range_select(stage_range_select), .stage_drive(stage_drive),
    .divide_ratio(divide_ratio), .phase_setting(phase_setting)
  );

  // 40 MHz clock
  always #12.5 sys_clk = ~sys_clk;

  // Verdict and end of run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Compare seen against expected
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One classic cycle; entered just after a rising edge, request held until ack is sampled
  task automatic wb_xfer(input logic [31:0] a, input logic we, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    wb_adr_i <= a;
    wb_we_i  <= we;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      n_fail++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, 1'b0, 1'b1);
      wrap_up();
    end else begin
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
      @(posedge sys_clk);
    end
  endtask

  task automatic wr_reg(input logic [7:0] ofs, input logic [31:0] d);
    logic [31:0] q;
    wb_xfer(OSC_BASE_ADDR + {24'h0, ofs}, 1'b1, d, q);
  endtask

  task automatic rd_reg(input logic [7:0] ofs, input logic [31:0] exp);
    wb_xfer(OSC_BASE_ADDR + {24'h0, ofs}, 1'b0, 32'h0, rd);
    check(rd, exp);
  endtask

  // Poll the stable flag the way software would, with a bounded count
  task automatic wait_stable();
    int n;
    n = 0;
    do begin
      wb_xfer(OSC_BASE_ADDR + 32'h18, 1'b0, 32'h0, rd);
      n++;
    end while (rd[STABLE_BIT] !== 1'b1 && n < 40);
    if (rd[STABLE_BIT] !== 1'b1) begin
      n_fail++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, rd, 32'h80000000);
      wrap_up();
    end
  endtask

  initial begin
    sys_clk = 1'b0;
    srst = 1'b1;
    wb_adr_i = 32'h0;
    wb_dat_i = 32'h0;
    wb_sel_i = 4'h0;
    wb_we_i = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wake_irq = 1'b0;
    osc_sample = 1'b1;
    osc_tick = 1'b0;
    n_fail = 0;
    n_checks = 0;
    range_code = '{RANGE_LOW, RANGE_MEDIUM, RANGE_HIGH, RANGE_OVER, 12'h123};
    range_exp = '{STAGES_8, STAGES_6, STAGES_4, STAGES_2, STAGES_8};
    repeat (16) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);

    // Power-up values and decode
    check({31'h0, osc_enable}, 32'h1);
    check({30'h0, stage_range_select}, {30'h0, STAGES_8});
    rd_reg(OFS_CONTROL, 32'h00FABAA0);
    rd_reg(OFS_PAUSE, WAKE_CODE);
    rd_reg(OFS_RANDOM, 32'h1);
    rd_reg(8'h24, 32'h0);
    wb_xfer(32'h40070000, 1'b1, {8'h0, ENABLE_OFF, RANGE_LOW}, rd);
    check({31'h0, osc_enable}, 32'h1);
    wait_stable();
    check(rd, 32'h80011000);
    $display("test reset done");

    // Every range code, then an undefined one that raises the flag
    // Codes rise one step at a time; the overspeed code is set only to prove its decode
    for (int i = 0; i < 5; i++) begin
      wr_reg(OFS_CONTROL, {8'hFF, ENABLE_ON, range_code[i]});
      repeat (2) @(posedge sys_clk);
      check({30'h0, stage_range_select}, {30'h0, range_exp[i]});
    end
    rd_reg(OFS_CONTROL, {8'h00, ENABLE_ON, 12'h123});
    rd_reg(OFS_STATUS, 32'h81011000);
    wr_reg(OFS_STATUS, 32'h01000000);
    rd_reg(OFS_STATUS, 32'h80011000);
    $display("test range done");

    // Drive fields: popcounts 1,2,2,3 give 8'hE9; a wrong key zeroes them
    wr_reg(OFS_DRIVE_LOW, 32'h9696F351);
    repeat (2) @(posedge sys_clk);
    check({16'h0, stage_drive}, 32'h000000E9);
    rd_reg(OFS_DRIVE_LOW, 32'h96967351);
    wr_reg(OFS_DRIVE_HIGH, 32'h96960007);
    repeat (2) @(posedge sys_clk);
    check({16'h0, stage_drive}, 32'h000003E9);
    wr_reg(OFS_DRIVE_LOW, 32'h12347777);
    wr_reg(OFS_DRIVE_HIGH, 32'h96950007);
    repeat (2) @(posedge sys_clk);
    check({16'h0, stage_drive}, 32'h0);
    wr_reg(OFS_STATUS, 32'h01000000);
    $display("test drive done");

    // Divider and phase keys; a bad key falls back and is flagged
    check({26'h0, divide_ratio}, 32'h10);
    check({28'h0, phase_setting}, 32'h8);
    wr_reg(OFS_DIVIDER, 32'h00000AA5);
    wr_reg(OFS_PHASE, 32'h00000AA5);
    repeat (2) @(posedge sys_clk);
    check({26'h0, divide_ratio}, 32'h5);
    check({28'h0, phase_setting}, 32'h5);
    rd_reg(OFS_STATUS, 32'h80011000);
    wr_reg(OFS_DIVIDER, 32'h00000000);
    wr_reg(OFS_PHASE, 32'h00000001);
    repeat (2) @(posedge sys_clk);
    check({26'h0, divide_ratio}, 32'h1F);
    check({28'h0, phase_setting}, 32'h8);
    rd_reg(OFS_STATUS, 32'h81011000);
    wr_reg(OFS_STATUS, 32'h01000000);
    $display("test divider done");

    // Disable code, then a stray code that must keep it running; the system clock is elsewhere
    wr_reg(OFS_CONTROL, {8'h00, ENABLE_OFF, RANGE_LOW});
    repeat (2) @(posedge sys_clk);
    check({31'h0, osc_enable}, 32'h0);
    rd_reg(OFS_STATUS, 32'h0);
    wr_reg(OFS_CONTROL, {8'h00, 12'h123, RANGE_LOW});
    repeat (2) @(posedge sys_clk);
    check({31'h0, osc_enable}, 32'h1);
    wr_reg(OFS_CONTROL, {8'h00, ENABLE_ON, RANGE_LOW});
    wr_reg(OFS_STATUS, 32'h01000000);
    wait_stable();
    check(rd, 32'h80011000);
    $display("test enable done");

    // Pause holds until a wake event, then the stable flag returns
    // The wake line is ready and clocks are moved before the pause code goes out
    wr_reg(OFS_PAUSE, PAUSE_CODE);
    repeat (2) @(posedge sys_clk);
    check({31'h0, osc_stop}, 32'h1);
    rd_reg(OFS_PAUSE, PAUSE_CODE);
    rd_reg(OFS_STATUS, 32'h00001000);
    repeat (60) @(posedge sys_clk);
    check({31'h0, osc_stop}, 32'h1);
    wake_irq <= 1'b1;
    @(posedge sys_clk);
    wake_irq <= 1'b0;
    repeat (2) @(posedge sys_clk);
    check({31'h0, osc_stop}, 32'h0);
    rd_reg(OFS_STATUS, 32'h00011000);
    wait_stable();
    check(rd, 32'h80011000);
    rd_reg(OFS_PAUSE, WAKE_CODE);
    wr_reg(OFS_PAUSE, 32'h12345678);
    rd_reg(OFS_PAUSE, WAKE_CODE);
    $display("test pause done");

    // Random bit follows the oscillator sample; counter stops at zero
    osc_sample <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rd_reg(OFS_RANDOM, 32'h0);
    wr_reg(OFS_DOWN_COUNT, 32'h3);
    osc_tick <= 1'b1;
    repeat (5) @(posedge sys_clk);
    osc_tick <= 1'b0;
    rd_reg(OFS_DOWN_COUNT, 32'h0);
    wr_reg(OFS_DOWN_COUNT, 32'h5);
    osc_tick <= 1'b1;
    repeat (2) @(posedge sys_clk);
    osc_tick <= 1'b0;
    rd_reg(OFS_DOWN_COUNT, 32'h3);
    $display("test counter done");
    wrap_up();
  end
endmodule
`default_nettype wire
